// >>> rtl/dsd_pkg.sv
// What this block does
// - Select bit picks deep or ordinary sleep
// - Flag brown-out seen by sleep monitor
// - Sleep brown-out never wakes, re-arms power-on
// - Hold bit keeps pins frozen until cleared
// - Control bits except hold reset only outside deep sleep
// - Latch one flag per deep-sleep wake event
// - Flag faults that may corrupt settings
// - Setting select bit clears all wake flags
// - Flag main-supply brown-out reset
// - Flag main-supply power-on, separate from core
// - Flag backup absent or too low
// - Backup power-on flag set at first power-up
// - Flag power-on exit with backup present
// - Supply flags: hardware sets, software clears
// - Main-supply return outside deep sleep resets all but supply flags and, while backup is present and not low, retained words
// - Doze enable slows the CPU clock
// - Three-bit ratio, 1:1 to 1:128, default 1:8
// - Peripherals full rate, CPU slot synchronous
// - Optional interrupt return to full speed
// - Power loss in deep sleep drops retained words and pin hold
// - Master clear in deep sleep keeps registers
package dsd_pkg;

  // Register byte offsets
  localparam logic [7:0]  DSD_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  DSD_OFS_WAKE   = 8'h04;
  localparam logic [7:0]  DSD_OFS_SUPPLY = 8'h08;
  localparam logic [7:0]  DSD_OFS_CLOCK_DIVIDER_REGISTER = 8'h0C;
  localparam logic [7:0]  DSD_OFS_RET0   = 8'h10;
  localparam logic [7:0]  DSD_OFS_RET1   = 8'h14;

  // Field positions
  localparam int          DSD_CTRL_SELECT = 15;
  localparam int          DSD_CTRL_BROWN  = 1;
  localparam int          DSD_CTRL_HOLD   = 0;
  localparam int          DSD_WAKE_PINCHG = 8;
  localparam int          DSD_WAKE_FAULT  = 7;
  localparam int          DSD_WAKE_WDOG   = 4;
  localparam int          DSD_WAKE_ALARM  = 3;
  localparam int          DSD_WAKE_MASTER_CLEAR_PIN   = 2;
  localparam int          DSD_SUP_BOR     = 3;
  localparam int          DSD_SUP_POR     = 2;
  localparam int          DSD_SUP_BPOR    = 1;
  localparam int          DSD_SUP_BEXIT   = 0;
  localparam int          DSD_CLK_ROI     = 15;
  localparam int          DSD_CLK_RAT_HI  = 14;
  localparam int          DSD_CLK_RAT_LO  = 12;
  localparam int          DSD_CLK_DOZE    = 11;

  // Implemented bits of each register
  localparam logic [15:0] DSD_CTRL_MASK   = 16'h8003;
  localparam logic [15:0] DSD_WAKE_MASK   = 16'h019C;
  localparam logic [15:0] DSD_SUP_MASK    = 16'h000F;
  localparam logic [15:0] DSD_CLK_MASK    = 16'hF800;

  // Reset values
  localparam logic [15:0] DSD_CTRL_RST    = 16'h0000;
  localparam logic [15:0] DSD_WAKE_RST    = 16'h0000;
  localparam logic [15:0] DSD_SUP_RST     = 16'h000E;
  localparam logic [15:0] DSD_CLK_RST     = 16'h3000;
  localparam logic [15:0] DSD_RET_RST     = 16'h0000;

  typedef enum logic [1:0] {
    DSD_RUN   = 2'b00,
    DSD_SLEEP = 2'b01,
    DSD_DEEP  = 2'b11
  } dsd_state_t;

  // Events from pins or slow always-on logic
  typedef struct packed {
    logic pin_change;
    logic watchdog;
    logic alarm;
    logic master_clear_pin_pin;
    logic fault;
    logic ds_brownout;
    logic backup_absent;
    logic backup_low;
  } dsd_pins_t;

  // Pulses from the reset controller, same clock
  typedef struct packed {
    logic vdd_por;
    logic vdd_bor;
  } dsd_rst_t;

endpackage

// >>> rtl/dsd_core.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dsd_core (
  input  wire logic               clk_i,     // System clock, 20 MHz
  input  wire logic               rstn_i,    // First power-up reset, active low
  input  wire logic [7:0]         addr_i,    // Register byte address
  input  wire logic [15:0]        wdata_i,   // Write data
  input  wire logic               we_i,      // Write strobe
  input  wire logic               re_i,      // Read strobe
  output logic      [15:0]        rdata_o,   // Read data, cycle after strobe
  input  wire logic               power_save_instruction_i,  // Power-save instruction pulse
  input  wire logic               irq_i,     // Interrupt request level
  input  wire logic               ds_bor_en_i, // Sleep brown-out monitor on
  input  wire dsd_pkg::dsd_pins_t pins_i,    // Asynchronous event inputs
  input  wire dsd_pkg::dsd_rst_t  rst_ev_i,  // Reset controller pulses
  output logic                    sleep_o,   // Ordinary sleep active
  output logic                    deep_sleep_o, // Deep sleep active
  output logic                    io_hold_o, // Pins frozen
  output logic                    por_rearm_o, // Re-arm power-on circuit
  output logic                    cpu_clk_en_o // CPU clock slot enable
);
  import dsd_pkg::*;

  dsd_state_t  st_reg;
  dsd_pins_t   s1_reg, s2_reg, s3_reg, filt_reg;
  logic [15:0] ctrl_reg, wake_reg, sup_reg, clk_reg, ret0_reg, ret1_reg;
  logic [15:0] rdata_reg;
  logic [15:0] wake_next, sup_set;
  logic [6:0]  cnt_reg;
  logic        en_reg, rearm_reg;
  logic        wake_any, in_deep, por_ev, brown_deep, enter_deep;
  logic        wr_ctrl, wr_wake, wr_sup, wr_clk, doze_on;
  logic [2:0]  ratio;

  // Codes map to successive powers of two
  function automatic logic [6:0] dsd_doze_limit(input logic [2:0] r);
    logic [7:0] p;
    p = 8'h01 << r;
    return 7'(p - 8'h01);
  endfunction

  // Three-stage synchroniser, filtered once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg <= pins_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < $bits(dsd_pins_t); i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          filt_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // Decode
  assign wr_ctrl    = we_i && (addr_i == DSD_OFS_CTRL);
  assign wr_wake    = we_i && (addr_i == DSD_OFS_WAKE);
  assign wr_sup     = we_i && (addr_i == DSD_OFS_SUPPLY);
  assign wr_clk     = we_i && (addr_i == DSD_OFS_CLOCK_DIVIDER_REGISTER);
  assign in_deep    = (st_reg == DSD_DEEP);
  assign por_ev     = rst_ev_i.vdd_por;
  // Brown-out is left out of the wake terms on purpose
  assign wake_any   = filt_reg.pin_change | filt_reg.watchdog | filt_reg.alarm |
                      filt_reg.master_clear_pin_pin | filt_reg.fault;
  assign brown_deep = in_deep && ds_bor_en_i && filt_reg.ds_brownout;
  assign enter_deep = (st_reg == DSD_RUN) && power_save_instruction_i && ctrl_reg[DSD_CTRL_SELECT];
  assign doze_on    = clk_reg[DSD_CLK_DOZE];
  assign ratio      = clk_reg[DSD_CLK_RAT_HI:DSD_CLK_RAT_LO];

  // Power state
  always_ff @(posedge clk_i) begin
    if (!rstn_i || por_ev) begin
      st_reg <= DSD_RUN;
    end else begin
      unique case (st_reg)
        DSD_RUN: begin
          if (power_save_instruction_i) begin
            st_reg <= ctrl_reg[DSD_CTRL_SELECT] ? DSD_DEEP : DSD_SLEEP;
          end
        end
        DSD_SLEEP: begin
          if (irq_i || wake_any) begin
            st_reg <= DSD_RUN;
          end
        end
        DSD_DEEP: begin
          // Master clear wakes but keeps the registers
          if (wake_any) begin
            st_reg <= DSD_RUN;
          end
        end
        default: st_reg <= DSD_RUN;
      endcase
    end
  end

  // Deep-sleep control; select and brown-out bits persist across deep-sleep power-on
  always_ff @(posedge clk_i) begin
    if (!rstn_i || (por_ev && !in_deep)) begin
      ctrl_reg <= DSD_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg[DSD_CTRL_SELECT] <= wdata_i[DSD_CTRL_SELECT];
      end
      // Set wins over a clearing write
      if (brown_deep) begin
        ctrl_reg[DSD_CTRL_BROWN] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_reg[DSD_CTRL_BROWN] <= wdata_i[DSD_CTRL_BROWN];
      end
      // Loss of power in deep sleep releases pins at once
      if (brown_deep || por_ev) begin
        ctrl_reg[DSD_CTRL_HOLD] <= 1'b0;
      end else if (enter_deep) begin
        ctrl_reg[DSD_CTRL_HOLD] <= 1'b1;
      end else if (wr_ctrl && !wdata_i[DSD_CTRL_HOLD]) begin
        ctrl_reg[DSD_CTRL_HOLD] <= 1'b0;
      end
    end
  end

  // Re-arm pulse for the power-on circuit
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rearm_reg <= 1'b0;
    end else begin
      rearm_reg <= brown_deep;
    end
  end

  // Wake sources: clear on select write, then hardware sets on top
  always_comb begin
    wake_next = wake_reg;
    if (wr_ctrl && wdata_i[DSD_CTRL_SELECT]) begin
      wake_next = '0;
    end else if (wr_wake) begin
      wake_next = wdata_i & DSD_WAKE_MASK;
    end
    if (in_deep) begin
      wake_next[DSD_WAKE_PINCHG] = wake_next[DSD_WAKE_PINCHG] | filt_reg.pin_change;
      wake_next[DSD_WAKE_WDOG]   = wake_next[DSD_WAKE_WDOG] | filt_reg.watchdog;
      wake_next[DSD_WAKE_ALARM]  = wake_next[DSD_WAKE_ALARM] | filt_reg.alarm;
      wake_next[DSD_WAKE_MASTER_CLEAR_PIN]   = wake_next[DSD_WAKE_MASTER_CLEAR_PIN] | filt_reg.master_clear_pin_pin;
      wake_next[DSD_WAKE_FAULT]  = wake_next[DSD_WAKE_FAULT] | filt_reg.fault;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || (por_ev && !in_deep)) begin
      wake_reg <= DSD_WAKE_RST;
    end else begin
      wake_reg <= wake_next;
    end
  end

  // Supply flags: set terms from hardware only
  always_comb begin
    sup_set                = '0;
    sup_set[DSD_SUP_BOR]   = rst_ev_i.vdd_bor;
    sup_set[DSD_SUP_POR]   = por_ev;
    sup_set[DSD_SUP_BPOR]  = filt_reg.backup_absent | filt_reg.backup_low;
    sup_set[DSD_SUP_BEXIT] = por_ev && !filt_reg.backup_absent;
  end

  // Writes only clear; reset value marks the very first power-up
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sup_reg <= DSD_SUP_RST;
    end else if (wr_sup) begin
      sup_reg <= (sup_reg & wdata_i) | sup_set;
    end else begin
      sup_reg <= sup_reg | sup_set;
    end
  end

  // Retained words survive supply return unless backup or deep state is lost
  always_ff @(posedge clk_i) begin
    if (!rstn_i || brown_deep ||
        (por_ev && (in_deep || filt_reg.backup_absent || filt_reg.backup_low))) begin
      ret0_reg <= DSD_RET_RST;
      ret1_reg <= DSD_RET_RST;
    end else begin
      if (we_i && addr_i == DSD_OFS_RET0) begin
        ret0_reg <= wdata_i;
      end
      if (we_i && addr_i == DSD_OFS_RET1) begin
        ret1_reg <= wdata_i;
      end
    end
  end

  // Clock divider; interrupt return beats a same-cycle write
  always_ff @(posedge clk_i) begin
    if (!rstn_i || por_ev) begin
      clk_reg <= DSD_CLK_RST;
    end else begin
      if (wr_clk) begin
        clk_reg <= wdata_i & DSD_CLK_MASK;
      end
      if (clk_reg[DSD_CLK_ROI] && doze_on && irq_i) begin
        clk_reg[DSD_CLK_DOZE] <= 1'b0;
      end
    end
  end

  // CPU slot: one enable per ratio period, same clock as peripherals
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
      en_reg  <= 1'b1;
    end else if (!doze_on) begin
      cnt_reg <= '0;
      en_reg  <= 1'b1;
    end else if (cnt_reg >= dsd_doze_limit(ratio)) begin
      cnt_reg <= '0;
      en_reg  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
      en_reg  <= 1'b0;
    end
  end

  // Read port; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_reg <= '0;
    end else if (re_i) begin
      unique case (addr_i)
        DSD_OFS_CTRL:   rdata_reg <= ctrl_reg & DSD_CTRL_MASK;
        DSD_OFS_WAKE:   rdata_reg <= wake_reg & DSD_WAKE_MASK;
        DSD_OFS_SUPPLY: rdata_reg <= sup_reg & DSD_SUP_MASK;
        DSD_OFS_CLOCK_DIVIDER_REGISTER: rdata_reg <= clk_reg & DSD_CLK_MASK;
        DSD_OFS_RET0:   rdata_reg <= ret0_reg;
        DSD_OFS_RET1:   rdata_reg <= ret1_reg;
        default:        rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata_o      = rdata_reg;
  assign sleep_o      = (st_reg == DSD_SLEEP);
  assign deep_sleep_o = (st_reg == DSD_DEEP);
  assign io_hold_o    = ctrl_reg[DSD_CTRL_HOLD];
  assign por_rearm_o  = rearm_reg;
  assign cpu_clk_en_o = en_reg;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_doze_gap;
    !cpu_clk_en_o ##1 cpu_clk_en_o;
  endsequence

  a_deep_entry: assert property (
    (st_reg == DSD_RUN && power_save_instruction_i && ctrl_reg[DSD_CTRL_SELECT] && !por_ev)
    |=> deep_sleep_o) else $error("deep sleep not entered");
  a_plain_sleep: assert property (
    (st_reg == DSD_RUN && power_save_instruction_i && !ctrl_reg[DSD_CTRL_SELECT] && !por_ev)
    |=> sleep_o && !deep_sleep_o) else $error("ordinary sleep not entered");
  a_brown_flag: assert property (
    (brown_deep && !por_ev) |=> ctrl_reg[DSD_CTRL_BROWN] && io_hold_o == 1'b0)
    else $error("sleep brown-out flag missing");
  a_brown_nowake: assert property (
    (in_deep && !wake_any && !por_ev) |=> deep_sleep_o)
    else $error("left deep sleep without wake event");
  a_rearm_pulse: assert property (
    brown_deep |=> por_rearm_o) else $error("re-arm pulse missing");
  a_hold_entry: assert property (
    (enter_deep && !por_ev) |=> io_hold_o && deep_sleep_o)
    else $error("pins not held on deep entry");
  a_wake_latch: assert property (
    (in_deep && filt_reg.watchdog && !por_ev) |=> wake_reg[DSD_WAKE_WDOG] && !deep_sleep_o)
    else $error("watchdog wake not latched");
  a_wake_clear: assert property (
    (wr_ctrl && wdata_i[DSD_CTRL_SELECT] && !in_deep && !por_ev) |=> wake_reg == 16'h0000)
    else $error("wake flags not cleared");
  a_sup_noset: assert property (
    (sup_set == 16'h0000) |=> (sup_reg & ~$past(sup_reg)) == 16'h0000)
    else $error("supply flag set by software");
  a_doze_ratio: assert property (
    (cpu_clk_en_o && doze_on && ratio == 3'h1 && $past(cpu_clk_en_o) == 1'b0) |=> s_doze_gap)
    else $error("doze 1:2 spacing wrong");
  a_roi_restore: assert property (
    (clk_reg[DSD_CLK_ROI] && doze_on && irq_i && !por_ev) |=> !doze_on)
    else $error("interrupt did not restore speed");
  a_roi_keep: assert property (
    (!clk_reg[DSD_CLK_ROI] && doze_on && irq_i && !wr_clk && !por_ev) |=> doze_on)
    else $error("interrupt changed doze");

endmodule // dsd_core
`default_nettype wire

// >>> verification/tb_deep_sleep_status_and_doze.sv
`timescale 1ns/1ps
`default_nettype none
module tb_deep_sleep_status_and_doze;
  import dsd_pkg::*;

  logic        clk_i       = 1'b0;
  logic        rstn_i      = 1'b0;
  logic [7:0]  addr_i      = 8'h00;
  logic [15:0] wdata_i     = 16'h0000;
  logic        we_i        = 1'b0;
  logic        re_i        = 1'b0;
  logic [15:0] rdata_o;
  logic        power_save_instruction_i    = 1'b0;
  logic        irq_i       = 1'b0;
  logic        ds_bor_en_i = 1'b0;
  dsd_pins_t   pins_i      = '0;
  dsd_rst_t    rst_ev_i    = '0;
  logic        sleep_o, deep_sleep_o, io_hold_o, por_rearm_o, cpu_clk_en_o;
  logic [15:0] q[$];
  int          errors      = 0;
  int          comparisons = 0;
  logic [31:0] seed        = 32'h0000000D;
  logic        re_d        = 1'b0;
  logic        rearm_seen  = 1'b0;
  logic [15:0] rval, n;
  int          wb[5] = '{DSD_WAKE_PINCHG, DSD_WAKE_WDOG, DSD_WAKE_ALARM, DSD_WAKE_MASTER_CLEAR_PIN,
                         DSD_WAKE_FAULT};

  dsd_core dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .power_save_instruction_i(power_save_instruction_i), .irq_i(irq_i),
    .ds_bor_en_i(ds_bor_en_i), .pins_i(pins_i), .rst_ev_i(rst_ev_i), .sleep_o(sleep_o),
    .deep_sleep_o(deep_sleep_o), .io_hold_o(io_hold_o), .por_rearm_o(por_rearm_o),
    .cpu_clk_en_o(cpu_clk_en_o)
  );

  // 20 MHz system clock
  always #25 clk_i = ~clk_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Wait n edges, then step past the edge so outputs have settled
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    we_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i    <= 1'b0;
  endtask

  // Expectation is queued here, compared by the read monitor
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_i);
    re_i   <= 1'b1;
    addr_i <= a;
    q.push_back(e);
    @(posedge clk_i);
    re_i   <= 1'b0;
  endtask

  task automatic pwr();
    @(posedge clk_i);
    power_save_instruction_i <= 1'b1;
    @(posedge clk_i);
    power_save_instruction_i <= 1'b0;
    tick(0);
  endtask

  task automatic ev(input logic [1:0] v);
    @(posedge clk_i);
    rst_ev_i <= v;
    @(posedge clk_i);
    rst_ev_i <= '0;
    tick(1);
  endtask

  task automatic irq_pulse();
    @(posedge clk_i);
    irq_i <= 1'b1;
    @(posedge clk_i);
    irq_i <= 1'b0;
    tick(2);
  endtask

  // Count CPU clock slots over a window that every ratio divides evenly
  task automatic count_en(output logic [15:0] c);
    c = 16'h0000;
    repeat (256) begin
      @(posedge clk_i);
      #1;
      if (cpu_clk_en_o === 1'b1) c = c + 16'h0001;
    end
  endtask

  // Read data is only valid in the cycle after the strobe
  always @(posedge clk_i) begin
    re_d <= re_i;
    if (por_rearm_o === 1'b1) rearm_seen <= 1'b1;
    if (re_d) chk(rdata_o, q.pop_front());
  end

  // Hang guard, several times the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(DSD_OFS_CTRL, 16'h0000);
    rd(DSD_OFS_WAKE, 16'h0000);
    rd(DSD_OFS_SUPPLY, 16'h000E);
    rd(DSD_OFS_CLOCK_DIVIDER_REGISTER, 16'h3000);
    wr(8'h18, 16'hFFFF);
    rd(8'h18, 16'h0000);
    $display("test reset_values done");
    // Supply flags: clear only, hardware sets
    wr(DSD_OFS_SUPPLY, 16'h0000);
    rd(DSD_OFS_SUPPLY, 16'h0000);
    wr(DSD_OFS_SUPPLY, 16'hFFFF);
    rd(DSD_OFS_SUPPLY, 16'h0000);
    ev(2'b01);
    rd(DSD_OFS_SUPPLY, 16'h0008);
    seed = xs(seed);
    rval = seed[15:0];
    wr(DSD_OFS_RET0, rval);
    ev(2'b10);
    rd(DSD_OFS_SUPPLY, 16'h000D);
    rd(DSD_OFS_RET0, rval);
    pins_i[1] <= 1'b1;
    tick(6);
    rd(DSD_OFS_SUPPLY, 16'h000F);
    pins_i <= '0;
    // Low backup alone must also raise the backup flag
    tick(6);
    wr(DSD_OFS_SUPPLY, 16'h0000);
    rd(DSD_OFS_SUPPLY, 16'h0000);
    pins_i[0] <= 1'b1;
    tick(6);
    rd(DSD_OFS_SUPPLY, 16'h0002);
    pins_i <= '0;
    $display("test supply_flags done");
    // Every wake source from deep sleep, select write clears flags
    wr(DSD_OFS_WAKE, 16'h019C);
    rd(DSD_OFS_WAKE, 16'h019C);
    for (int k = 0; k < 5; k++) begin
      wr(DSD_OFS_CTRL, 16'h8000);
      rd(DSD_OFS_WAKE, 16'h0000);
      pwr();
      chk(deep_sleep_o, 1'b1);
      chk(io_hold_o, 1'b1);
      pins_i[7 - k] <= 1'b1;
      tick(8);
      chk(deep_sleep_o, 1'b0);
      pins_i <= '0;
      rd(DSD_OFS_WAKE, 16'h0001 << wb[k]);
      rd(DSD_OFS_CTRL, 16'h8001);
      chk(io_hold_o, 1'b1);
      tick(4);
    end
    wr(DSD_OFS_CTRL, 16'h8000);
    tick(1);
    chk(io_hold_o, 1'b0);
    $display("test wake_sources done");
    // Brown-out in deep sleep, then power-on inside and outside deep sleep
    // Monitor off first: brown-out leaves flag and hold alone
    pwr();
    pins_i[2] <= 1'b1;
    tick(8);
    chk(deep_sleep_o, 1'b1);
    chk(rearm_seen, 1'b0);
    rd(DSD_OFS_CTRL, 16'h8001);
    pins_i <= '0;
    tick(6);
    ds_bor_en_i <= 1'b1;
    rearm_seen = 1'b0;
    pins_i[2] <= 1'b1;
    tick(8);
    chk(deep_sleep_o, 1'b1);
    chk(rearm_seen, 1'b1);
    chk(io_hold_o, 1'b0);
    pins_i <= '0;
    tick(4);
    rd(DSD_OFS_CTRL, 16'h8002);
    rd(DSD_OFS_RET0, 16'h0000);
    ev(2'b10);
    chk(deep_sleep_o, 1'b0);
    rd(DSD_OFS_CTRL, 16'h8002);
    ev(2'b10);
    rd(DSD_OFS_CTRL, 16'h0000);
    $display("test brownout_por done");
    // Ordinary sleep when select is clear
    pwr();
    chk(sleep_o, 1'b1);
    chk(deep_sleep_o, 1'b0);
    irq_pulse();
    chk(sleep_o, 1'b0);
    $display("test ordinary_sleep done");
    // Doze ratios, slot count per window is 256 / 2^code
    count_en(n);
    chk(n, 16'd256);
    for (int r = 0; r < 8; r++) begin
      wr(DSD_OFS_CLOCK_DIVIDER_REGISTER, 16'h0000);
      tick(2);
      wr(DSD_OFS_CLOCK_DIVIDER_REGISTER, {1'b0, r[2:0], 1'b1, 11'h000});
      tick(4);
      count_en(n);
      chk(n, 16'd256 >> r);
    end
    $display("test doze_ratios done");
    // Interrupt return to full speed only when enabled
    wr(DSD_OFS_CLOCK_DIVIDER_REGISTER, 16'hB800);
    irq_pulse();
    rd(DSD_OFS_CLOCK_DIVIDER_REGISTER, 16'hB000);
    wr(DSD_OFS_CLOCK_DIVIDER_REGISTER, 16'h3800);
    irq_pulse();
    rd(DSD_OFS_CLOCK_DIVIDER_REGISTER, 16'h3800);
    tick(3);
    $display("test doze_interrupt done");
    end_of_test();
  end
endmodule // tb_deep_sleep_status_and_doze
`default_nettype wire
